/* File: logic/aeh_pkg.sv */
// package: offsets, fields, resets and carriers of the audio handshake register block
package aeh_pkg;

    localparam int DATA_W = 32;
    localparam int ADDR_W = 8;

    // register byte offsets
    localparam logic [ADDR_W-1:0] OFF_HANDSHAKE     = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_CONTROL       = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_SINK_WINDOW   = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_PACKET_WINDOW = 8'h0C;

    // handshake register: ports b, c, d at 0, 4, 8; valid at +0, ready at +1
    localparam int NUM_PORTS       = 3;
    localparam int HS_PORT_STRIDE  = 4;
    localparam int HS_VALID_OFS    = 0;
    localparam int HS_READY_OFS    = 1;
    localparam logic [DATA_W-1:0] HANDSHAKE_RESET = 32'h0000_0000;

    // control register fields
    localparam int PKT_ADDR_LSB   = 0;
    localparam int PKT_ADDR_W     = 4;
    localparam int ACK_BIT        = 4;
    localparam int CAP_ADDR_LSB   = 5;
    localparam int CAP_ADDR_W     = 5;
    localparam int BUF_SIZE_LSB   = 10;
    localparam int BUF_SIZE_W     = 5;
    localparam int PKT_TYPE_LSB   = 18;
    localparam int PKT_TYPE_W     = 3;
    localparam logic [BUF_SIZE_W-1:0] BUF_SIZE_DWORDS = 5'h15;

    // window addressing
    localparam logic [CAP_ADDR_W-1:0] CAP_WRAP_LAST = 5'h0F;
    localparam logic [PKT_ADDR_W-1:0] PKT_WRAP_LAST = 4'hF;
    localparam int PKT_TYPE_SEL_W = 2;
    localparam logic [PKT_TYPE_W-1:0] PKT_TYPES   = 3'h4;
    localparam logic [PKT_ADDR_W-1:0] PKT_DWORDS  = 4'h8;
    localparam int CODEC_IDX_W = 8;

    typedef enum logic [1:0] {
        CMD_GET_VALID,
        CMD_GET_SINK_BYTE,
        CMD_SET_PKT_INDEX,
        CMD_GET_PKT_BYTE
    } aeh_codec_cmd_t;

    typedef struct packed {
        logic              valid;
        logic              write;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } aeh_mmio_req_t;

    typedef struct packed {
        logic              valid;
        logic [DATA_W-1:0] rdata;
    } aeh_mmio_rsp_t;

    typedef struct packed {
        logic                   valid;
        aeh_codec_cmd_t         cmd;
        logic [1:0]             port;
        logic [CODEC_IDX_W-1:0] index;
    } aeh_codec_req_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } aeh_codec_rsp_t;

    typedef struct packed {
        logic                      valid;
        logic [PKT_TYPE_SEL_W-1:0] ptype;
        logic [PKT_ADDR_W-1:0]     index;
        logic [DATA_W-1:0]         data;
    } aeh_pkt_load_t;

    typedef struct packed {
        logic       valid;
        logic [1:0] port;
        logic       cap_valid;
        logic       prot_ready;
    } aeh_unsol_t;

endpackage

/* File: logic/aeh_port.sv */
// one port's capability-valid and protection-ready pair with set event
`timescale 1ns/1ps
module aeh_port (
    input  wire logic       sys_clk,
    input  wire logic       sys_rst,
    input  wire logic       clear,
    input  wire logic       wr_en,
    input  wire logic [1:0] wr_bits,
    output logic            cap_valid,
    output logic            prot_ready,
    output logic            set_event
);
    import aeh_pkg::*;

    typedef struct packed {
        logic cap_valid;
        logic prot_ready;
        logic set_event;
    } aeh_port_state_t;

    aeh_port_state_t state;
    aeh_port_state_t next_state;

    always_comb begin
        next_state           = state;
        next_state.set_event = 1'b0;
        if (clear) begin
            next_state = '0;
        end else if (wr_en) begin
            next_state.cap_valid  = wr_bits[HS_VALID_OFS];
            next_state.prot_ready = wr_bits[HS_READY_OFS];
            // a 0 to 1 change on either bit raises the event
            next_state.set_event  = (wr_bits[HS_VALID_OFS] & ~state.cap_valid)
                                  | (wr_bits[HS_READY_OFS] & ~state.prot_ready);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign cap_valid  = state.cap_valid;
    assign prot_ready = state.prot_ready;
    assign set_event  = state.set_event;

endmodule // aeh_port

/* File: logic/aeh_regs.sv */
// audio/display handshake registers, sink capability window and packet window
// Function
// - writable read-acknowledge bit at position 4
// - packet address bits 3:0, wraps past 0xF
// - packet address write immediate, reads current address
// - setting valid or ready sends unsolicited response
// - protection-ready bits 9,5,1; software writes one
// - valid bit mirrored to codec pin status
// - capability write advances address, wraps after 0xF
// - capability read advances address, wraps after 0xF
// - capability buffer cleared only by main reset
// - capability bytes returned to codec on get
// - invalid packet type or index reads zero
// - codec sets byte index, then fetches one byte
// - packet window shows addressed word; function/link reset clears
// - capability address bits 9:5, wraps, reads current
`timescale 1ns/1ps
module aeh_regs (
    input  wire logic                  sys_clk,
    input  wire logic                  sys_rst,
    input  wire logic                  func_rst,
    input  wire logic                  link_rst,
    input  wire aeh_pkg::aeh_mmio_req_t  mmio_req,
    output aeh_pkg::aeh_mmio_rsp_t       mmio_rsp,
    input  wire aeh_pkg::aeh_codec_req_t codec_req,
    output aeh_pkg::aeh_codec_rsp_t      codec_rsp,
    input  wire aeh_pkg::aeh_pkt_load_t  pkt_load,
    output aeh_pkg::aeh_unsol_t          unsol,
    output logic [aeh_pkg::NUM_PORTS-1:0] pin_cap_valid,
    output logic                         read_ack
);
    import aeh_pkg::*;

    localparam int PKT_BUF_AW = PKT_TYPE_SEL_W + PKT_ADDR_W;

    typedef struct packed {
        logic [CAP_ADDR_W-1:0]    cap_addr;
        logic                     ack;
        logic [PKT_ADDR_W-1:0]    pkt_addr;
        logic [PKT_TYPE_W-1:0]    pkt_type;
        logic [CODEC_IDX_W-1:0]   codec_pkt_index;
        logic [NUM_PORTS-1:0]     unsol_pend;
        logic [NUM_PORTS-1:0]     pin_valid;
        aeh_mmio_rsp_t            mmio_rsp;
        aeh_codec_rsp_t           codec_rsp;
        aeh_unsol_t               unsol;
    } aeh_regs_state_t;

    aeh_regs_state_t state;
    aeh_regs_state_t next_state;

    logic                   soft_clear;
    logic                   hs_wr;
    logic                   ctrl_wr;
    logic                   cap_wr;
    logic                   cap_rd;
    logic                   pkt_rd;
    logic [DATA_W-1:0]      cap_word_mmio;
    logic [DATA_W-1:0]      cap_word_codec;
    logic [DATA_W-1:0]      pkt_word_mmio;
    logic [DATA_W-1:0]      pkt_word_codec;
    logic [PKT_BUF_AW-1:0]  pkt_rd_addr_mmio;
    logic [PKT_BUF_AW-1:0]  pkt_rd_addr_codec;
    logic [PKT_BUF_AW-1:0]  pkt_wr_addr;
    logic                   pkt_type_ok;
    logic [NUM_PORTS-1:0]   port_valid;
    logic [NUM_PORTS-1:0]   port_ready;
    logic [NUM_PORTS-1:0]   port_event;
    logic [DATA_W-1:0]      hs_read;
    logic [DATA_W-1:0]      ctrl_read;

    // function and link resets clear everything but the capability buffer
    assign soft_clear = func_rst | link_rst;

    // one decode; an access in a soft reset cycle is dropped
    always_comb begin
        hs_wr   = 1'b0;
        ctrl_wr = 1'b0;
        cap_wr  = 1'b0;
        cap_rd  = 1'b0;
        pkt_rd  = 1'b0;
        if (mmio_req.valid && !soft_clear) begin
            unique case (mmio_req.addr)
                OFF_HANDSHAKE: begin
                    hs_wr = mmio_req.write;
                end
                OFF_CONTROL: begin
                    ctrl_wr = mmio_req.write;
                end
                OFF_SINK_WINDOW: begin
                    cap_wr = mmio_req.write;
                    cap_rd = !mmio_req.write;
                end
                OFF_PACKET_WINDOW: begin
                    pkt_rd = !mmio_req.write;
                end
                default: begin
                    pkt_rd = 1'b0;
                end
            endcase
        end
    end

    // types above three and words past seven read as zero
    assign pkt_type_ok       = state.pkt_type < PKT_TYPES;
    assign pkt_rd_addr_mmio  = {state.pkt_type[PKT_TYPE_SEL_W-1:0], state.pkt_addr};
    assign pkt_rd_addr_codec = {state.pkt_type[PKT_TYPE_SEL_W-1:0],
                                state.codec_pkt_index[2 +: PKT_ADDR_W]};
    assign pkt_wr_addr       = {pkt_load.ptype, pkt_load.index};

    // capability buffer survives function and link resets
    aeh_wbuf #(
        .ADDR_W (CAP_ADDR_W),
        .WIDTH  (DATA_W)
    ) u_sink_buf (
        .sys_clk   (sys_clk),
        .sys_rst   (sys_rst),
        .clear     (1'b0),
        .wr_en     (cap_wr),
        .wr_addr   (state.cap_addr),
        .wr_data   (mmio_req.wdata),
        .rd_addr_a (state.cap_addr),
        .rd_data_a (cap_word_mmio),
        .rd_addr_b (codec_req.index[2 +: CAP_ADDR_W]),
        .rd_data_b (cap_word_codec)
    );

    // packet buffer filled by the transmit side, word {type, index}
    aeh_wbuf #(
        .ADDR_W (PKT_BUF_AW),
        .WIDTH  (DATA_W)
    ) u_packet_buf (
        .sys_clk   (sys_clk),
        .sys_rst   (sys_rst),
        .clear     (soft_clear),
        .wr_en     (pkt_load.valid),
        .wr_addr   (pkt_wr_addr),
        .wr_data   (pkt_load.data),
        .rd_addr_a (pkt_rd_addr_mmio),
        .rd_data_a (pkt_word_mmio),
        .rd_addr_b (pkt_rd_addr_codec),
        .rd_data_b (pkt_word_codec)
    );

    // one handshake pair per port, pairs four bits apart
    for (genvar i = 0; i < NUM_PORTS; i++) begin : g_port
        aeh_port u_port (
            .sys_clk    (sys_clk),
            .sys_rst    (sys_rst),
            .clear      (soft_clear),
            .wr_en      (hs_wr),
            .wr_bits    (mmio_req.wdata[i*HS_PORT_STRIDE +: 2]),
            .cap_valid  (port_valid[i]),
            .prot_ready (port_ready[i]),
            .set_event  (port_event[i])
        );
    end

    // readback images; reserved bits stay zero
    always_comb begin
        hs_read = HANDSHAKE_RESET;
        for (int i = 0; i < NUM_PORTS; i++) begin
            hs_read[i*HS_PORT_STRIDE + HS_VALID_OFS] = port_valid[i];
            hs_read[i*HS_PORT_STRIDE + HS_READY_OFS] = port_ready[i];
        end
        ctrl_read = '0;
        ctrl_read[PKT_ADDR_LSB +: PKT_ADDR_W] = state.pkt_addr;
        ctrl_read[ACK_BIT]                    = state.ack;
        ctrl_read[CAP_ADDR_LSB +: CAP_ADDR_W] = state.cap_addr;
        ctrl_read[BUF_SIZE_LSB +: BUF_SIZE_W] = BUF_SIZE_DWORDS;
        ctrl_read[PKT_TYPE_LSB +: PKT_TYPE_W] = state.pkt_type;
    end

    always_comb begin
        next_state = state;
        next_state.mmio_rsp  = '0;
        next_state.codec_rsp = '0;
        next_state.unsol     = '0;
        // pin mirror lags the register by one cycle
        next_state.pin_valid = port_valid;

        // register bus
        if (mmio_req.valid) begin
            next_state.mmio_rsp.valid = 1'b1;
            next_state.mmio_rsp.rdata = '0;
            if (ctrl_wr) begin
                next_state.pkt_addr = mmio_req.wdata[PKT_ADDR_LSB +: PKT_ADDR_W];
                next_state.ack      = mmio_req.wdata[ACK_BIT];
                next_state.cap_addr = mmio_req.wdata[CAP_ADDR_LSB +: CAP_ADDR_W];
                next_state.pkt_type = mmio_req.wdata[PKT_TYPE_LSB +: PKT_TYPE_W];
            end
            if (cap_wr || cap_rd) begin
                // step past 0x0F wraps to zero; 0x1F wraps by width
                if (state.cap_addr == CAP_WRAP_LAST) begin
                    next_state.cap_addr = '0;
                end else begin
                    next_state.cap_addr = state.cap_addr + 1'b1;
                end
            end
            // packet reads step the window; writes to it are ignored
            if (pkt_rd) begin
                if (state.pkt_addr == PKT_WRAP_LAST) begin
                    next_state.pkt_addr = '0;
                end else begin
                    next_state.pkt_addr = state.pkt_addr + 1'b1;
                end
            end
            if (!mmio_req.write) begin
                unique case (mmio_req.addr)
                    OFF_HANDSHAKE: begin
                        next_state.mmio_rsp.rdata = hs_read;
                    end
                    OFF_CONTROL: begin
                        next_state.mmio_rsp.rdata = ctrl_read;
                    end
                    OFF_SINK_WINDOW: begin
                        next_state.mmio_rsp.rdata = cap_word_mmio;
                    end
                    OFF_PACKET_WINDOW: begin
                        if (pkt_type_ok && state.pkt_addr < PKT_DWORDS) begin
                            next_state.mmio_rsp.rdata = pkt_word_mmio;
                        end else begin
                            next_state.mmio_rsp.rdata = '0;
                        end
                    end
                    default: begin
                        next_state.mmio_rsp.rdata = '0;
                    end
                endcase
            end
        end

        // codec widget commands
        if (codec_req.valid) begin
            unique case (codec_req.cmd)
                CMD_GET_VALID: begin
                    next_state.codec_rsp.valid = 1'b1;
                    next_state.codec_rsp.data  = '0;
                    if (codec_req.port < 2'(NUM_PORTS)) begin
                        next_state.codec_rsp.data[0] = port_valid[codec_req.port];
                    end
                end
                CMD_GET_SINK_BYTE: begin
                    next_state.codec_rsp.valid = 1'b1;
                    next_state.codec_rsp.data  = cap_word_codec[codec_req.index[1:0]*8 +: 8];
                end
                // index set is silent; the byte fetch uses the stored index
                CMD_SET_PKT_INDEX: begin
                    next_state.codec_pkt_index = codec_req.index;
                end
                CMD_GET_PKT_BYTE: begin
                    next_state.codec_rsp.valid = 1'b1;
                    if (pkt_type_ok
                        && state.codec_pkt_index[CODEC_IDX_W-1:2] < 6'(PKT_DWORDS)) begin
                        next_state.codec_rsp.data =
                            pkt_word_codec[state.codec_pkt_index[1:0]*8 +: 8];
                    end else begin
                        next_state.codec_rsp.data = '0;
                    end
                end
            endcase
        end

        // unsolicited responses, one port per cycle, lowest first
        next_state.unsol_pend = state.unsol_pend;
        for (int i = NUM_PORTS - 1; i >= 0; i--) begin
            if (state.unsol_pend[i]) begin
                next_state.unsol.valid      = 1'b1;
                next_state.unsol.port       = 2'(i);
                next_state.unsol.cap_valid  = port_valid[i];
                next_state.unsol.prot_ready = port_ready[i];
            end
        end
        if (next_state.unsol.valid) begin
            next_state.unsol_pend[next_state.unsol.port] = 1'b0;
        end
        // a new event wins over the send that clears it
        next_state.unsol_pend = next_state.unsol_pend | port_event;

        if (soft_clear) begin
            next_state = '0;
        end
    end

    // main reset clears all; soft resets act through next_state
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    // every output is a register of the state
    assign mmio_rsp      = state.mmio_rsp;
    assign codec_rsp     = state.codec_rsp;
    assign unsol         = state.unsol;
    assign pin_cap_valid = state.pin_valid;
    assign read_ack      = state.ack;

endmodule // aeh_regs

/* File: logic/aeh_wbuf.sv */
// word buffer with one write port, two read ports and a whole-buffer clear
`timescale 1ns/1ps
module aeh_wbuf #(
    parameter int ADDR_W = 5,
    parameter int WIDTH  = 32
) (
    input  wire logic              sys_clk,
    input  wire logic              sys_rst,
    input  wire logic              clear,
    input  wire logic              wr_en,
    input  wire logic [ADDR_W-1:0] wr_addr,
    input  wire logic [WIDTH-1:0]  wr_data,
    input  wire logic [ADDR_W-1:0] rd_addr_a,
    output logic      [WIDTH-1:0]  rd_data_a,
    input  wire logic [ADDR_W-1:0] rd_addr_b,
    output logic      [WIDTH-1:0]  rd_data_b
);
    import aeh_pkg::*;

    typedef struct packed {
        logic [(1<<ADDR_W)-1:0][WIDTH-1:0] mem;
    } aeh_wbuf_state_t;

    aeh_wbuf_state_t state;
    aeh_wbuf_state_t next_state;

    always_comb begin
        next_state = state;
        if (clear) begin
            next_state = '0;
        end else if (wr_en) begin
            next_state.mem[wr_addr] = wr_data;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign rd_data_a = state.mem[rd_addr_a];
    assign rd_data_b = state.mem[rd_addr_b];

endmodule // aeh_wbuf

/* File: testbench/aeh_codec_model.sv */
// codec-side model issuing widget commands and taking the byte answers
`timescale 1ns/1ps
module aeh_codec_model (
    input  wire logic                    sys_clk,
    output aeh_pkg::aeh_codec_req_t      codec_req,
    input  wire aeh_pkg::aeh_codec_rsp_t codec_rsp
);
    import aeh_pkg::*;
    initial codec_req = '0;
    // one command per call; answer sampled one cycle after the request
    task automatic xfer(input aeh_codec_cmd_t c, input logic [1:0] p,
                        input logic [7:0] i, output aeh_codec_rsp_t r);
        @(posedge sys_clk) codec_req <= '{1'b1, c, p, i};
        @(posedge sys_clk) codec_req.valid <= 1'b0;
        #1 r = codec_rsp;
    endtask
endmodule // aeh_codec_model

/* File: testbench/aeh_regs_properties.sv */
// concurrent checks on the handshake register block ports
`timescale 1ns/1ps
module aeh_regs_properties (
    input wire logic                          sys_clk,
    input wire logic                          sys_rst,
    input wire logic                          func_rst,
    input wire logic                          link_rst,
    input wire aeh_pkg::aeh_mmio_req_t        mmio_req,
    input wire aeh_pkg::aeh_mmio_rsp_t        mmio_rsp,
    input wire aeh_pkg::aeh_codec_req_t       codec_req,
    input wire aeh_pkg::aeh_codec_rsp_t       codec_rsp,
    input wire aeh_pkg::aeh_pkt_load_t        pkt_load,
    input wire aeh_pkg::aeh_unsol_t           unsol,
    input wire logic [aeh_pkg::NUM_PORTS-1:0] pin_cap_valid,
    input wire logic                          read_ack
);
    import aeh_pkg::*;
    logic fr, rq, hs_wr, hs_rd, ct_wr, ct_rd, cd_get;
    assign fr     = func_rst | link_rst;
    assign rq     = mmio_req.valid & ~fr;
    assign hs_wr  = rq & mmio_req.write & (mmio_req.addr == OFF_HANDSHAKE);
    assign hs_rd  = rq & ~mmio_req.write & (mmio_req.addr == OFF_HANDSHAKE);
    assign ct_wr  = rq & mmio_req.write & (mmio_req.addr == OFF_CONTROL);
    assign ct_rd  = rq & ~mmio_req.write & (mmio_req.addr == OFF_CONTROL);
    assign cd_get = codec_req.valid & ~fr & (codec_req.cmd != CMD_SET_PKT_INDEX);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    AST_ACK: assert property (ct_wr |=> read_ack == $past(mmio_req.wdata[4]))
        else $error("ack bit does not follow write");
    AST_CTL_RB: assert property (ct_wr ##1 !(rq || fr) ##1 ct_rd |=>
        mmio_rsp.rdata[9:0] == $past(mmio_req.wdata[9:0], 3))
        else $error("window address readback wrong");
    AST_HS_RSV: assert property (hs_rd |=> (mmio_rsp.rdata & ~32'h0000_0333) == 32'h0000_0000)
        else $error("reserved handshake bits not zero");
    AST_PIN: assert property (hs_wr |-> ##2
        pin_cap_valid == $past({mmio_req.wdata[8], mmio_req.wdata[4], mmio_req.wdata[0]}, 2))
        else $error("pin valid mirror wrong");
    AST_UNSOL: assert property ($rose(pin_cap_valid[0]) |-> ##[0:3] (unsol.valid && unsol.port == 2'h0))
        else $error("no response for port b valid");
    AST_UNSOL_BITS: assert property (unsol.valid |-> unsol.port != 2'h3 &&
        unsol.cap_valid == pin_cap_valid[unsol.port])
        else $error("response bits differ from pin state");
    AST_CODEC_RSP: assert property (cd_get |=> codec_rsp.valid)
        else $error("codec get without response");
    AST_CODEC_SET: assert property (codec_req.valid && codec_req.cmd == CMD_SET_PKT_INDEX |=>
        !codec_rsp.valid)
        else $error("index set answered");
    AST_RSP: assert property (rq |=> mmio_rsp.valid)
        else $error("register access without response");
endmodule // aeh_regs_properties

bind aeh_regs aeh_regs_properties u_aeh_regs_properties (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .func_rst(func_rst), .link_rst(link_rst), .mmio_req(mmio_req), .mmio_rsp(mmio_rsp),
    .codec_req(codec_req), .codec_rsp(codec_rsp), .pkt_load(pkt_load), .unsol(unsol),
    .pin_cap_valid(pin_cap_valid), .read_ack(read_ack));

/* File: testbench/tb_top.sv */
// self-checking bench for the audio handshake register block
`timescale 1ns/1ps
module tb_top;
    import aeh_pkg::*;
    logic           sys_clk, sys_rst, func_rst, link_rst, read_ack;
    logic [2:0]     pin_cap_valid;
    aeh_mmio_req_t  mmio_req;
    aeh_mmio_rsp_t  mmio_rsp;
    aeh_codec_req_t codec_req;
    aeh_codec_rsp_t codec_rsp, cr;
    aeh_pkt_load_t  pkt_load;
    aeh_unsol_t     unsol;
    logic [31:0]    r;
    int fail_count, n_compared, hs, pa, ca, ack, pt, ci;
    int cap[32];
    int pkt[4][8];
    int uq[$];

    aeh_regs u_aeh_regs (.sys_clk(sys_clk), .sys_rst(sys_rst), .func_rst(func_rst),
        .link_rst(link_rst), .mmio_req(mmio_req), .mmio_rsp(mmio_rsp), .codec_req(codec_req),
        .codec_rsp(codec_rsp), .pkt_load(pkt_load), .unsol(unsol),
        .pin_cap_valid(pin_cap_valid), .read_ack(read_ack));
    aeh_codec_model u_aeh_codec_model (.sys_clk(sys_clk), .codec_req(codec_req),
        .codec_rsp(codec_rsp));

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    task automatic end_sim();
        if (fail_count == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic bad(input logic [31:0] g, input logic [31:0] e);
        fail_count++;
        $display("Error %0t: got %h expected %h", $time, g, e);
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) bad(g, e);
    endtask

    task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
        n_compared++;
        if (g !== e) bad(32'(g), 32'(e));
    endtask

    task automatic chk_evt(input aeh_unsol_t u, input int p);
        n_compared++;
        if (u !== {1'b1, p[1:0], hs[4*p], hs[4*p+1]}) bad(32'(u), 32'(p));
    endtask

    function automatic int nx(input int a);
        return (a == 15 || a == 31) ? 0 : a + 1;
    endfunction

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk) mmio_req <= '{1'b1, w, a, d};
        @(posedge sys_clk) mmio_req.valid <= 1'b0;
        #1 r = mmio_rsp.rdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        if (a == OFF_HANDSHAKE) begin
            for (int p = 0; p < 3; p++)
                if ((d[4*p +: 2] & ~hs[4*p +: 2]) != 0) uq.push_back(p);
            hs = d & 32'h0000_0333;
        end
        if (a == OFF_CONTROL) begin
            pa = d[3:0];
            ack = d[4];
            ca = d[9:5];
            pt = d[20:18];
        end
        if (a == OFF_SINK_WINDOW) begin
            cap[ca] = d;
            ca = nx(ca);
        end
        bus(1'b1, a, d);
        if (a == OFF_CONTROL) chk(32'(read_ack), 32'(ack));
        if (a == OFF_HANDSHAKE) repeat (4) @(posedge sys_clk);
        if (a == OFF_HANDSHAKE) chk(32'(pin_cap_valid), 32'({hs[8], hs[4], hs[0]}));
    endtask

    task automatic rd(input logic [7:0] a);
        logic [31:0] e;
        case (a)
            OFF_HANDSHAKE: e = hs;
            OFF_CONTROL: e = (pt << 18) | (BUF_SIZE_DWORDS << 10) | (ca << 5) | (ack << 4) | pa;
            OFF_SINK_WINDOW: e = cap[ca];
            OFF_PACKET_WINDOW: e = (pt > 3 || pa > 7) ? 0 : pkt[pt][pa];
            default: e = 0;
        endcase
        bus(1'b0, a, 32'h0000_0000);
        if (a == OFF_SINK_WINDOW) ca = nx(ca);
        if (a == OFF_PACKET_WINDOW) pa = (pa + 1) % 16;
        chk(r, e);
    endtask

    task automatic load(input int t, input int i, input logic [31:0] d);
        @(posedge sys_clk) pkt_load <= '{1'b1, t[1:0], i[3:0], d};
        @(posedge sys_clk) pkt_load.valid <= 1'b0;
        pkt[t][i] = d;
    endtask

    task automatic codec(input aeh_codec_cmd_t c, input int p, input int i);
        logic [7:0] e;
        u_aeh_codec_model.xfer(c, p[1:0], i[7:0], cr);
        case (c)
            CMD_GET_VALID: e = (p < 3) ? 8'(hs[4*p]) : 8'h00;
            CMD_GET_SINK_BYTE: e = cap[i[6:2]][8*i[1:0] +: 8];
            CMD_SET_PKT_INDEX: ci = i;
            default: e = (pt > 3 || ci[7:2] > 7) ? 8'h00 : pkt[pt][ci[4:2]][8*ci[1:0] +: 8];
        endcase
        if (c != CMD_SET_PKT_INDEX) chk_byte(cr.data, e);
    endtask

    task automatic pulse(input int k);
        @(posedge sys_clk) begin
            func_rst <= (k == 0);
            link_rst <= (k != 0);
        end
        @(posedge sys_clk) begin
            func_rst <= 1'b0;
            link_rst <= 1'b0;
        end
        {hs, pa, ca, ack, pt} = '0;
        foreach (pkt[i, j]) pkt[i][j] = 0;
    endtask

    always @(posedge sys_clk) begin
        if (unsol.valid === 1'b1) chk_evt(unsol, uq.size() ? uq.pop_front() : 3);
    end

    initial begin
        repeat (20000) @(posedge sys_clk);
        fail_count++;
        end_sim();
    end

    initial begin
        int st[2] = '{8, 28};
        {mmio_req, pkt_load, func_rst, link_rst} = '0;
        sys_rst = 1'b1;
        void'($urandom(31770));
        repeat (5) @(posedge sys_clk);
        sys_rst <= 1'b0;
        for (int k = 0; k < 5; k++)
            rd(8'(4 * k));
        for (int k = 0; k < 6; k++) begin
            wr(OFF_CONTROL, $urandom());
            rd(OFF_CONTROL);
        end
        foreach (st[s]) begin
            wr(OFF_CONTROL, 32'(st[s] << 5));
            repeat (12) wr(OFF_SINK_WINDOW, $urandom());
            rd(OFF_CONTROL);
            wr(OFF_CONTROL, 32'(st[s] << 5));
            repeat (20) rd(OFF_SINK_WINDOW);
            rd(OFF_CONTROL);
        end
        foreach (pkt[i, j]) load(i, j, $urandom());
        for (int t = 0; t < 5; t++) begin
            wr(OFF_CONTROL, 32'((t << 18) | 6));
            repeat (3) rd(OFF_PACKET_WINDOW);
            wr(OFF_CONTROL, 32'((t << 18) | 15));
            repeat (2) rd(OFF_PACKET_WINDOW);
            rd(OFF_CONTROL);
        end
        wr(OFF_CONTROL, 32'h0000_0002);
        wr(OFF_PACKET_WINDOW, $urandom());
        rd(OFF_PACKET_WINDOW);
        for (int k = 0; k < 10; k++) begin
            wr(OFF_HANDSHAKE, k == 0 ? 32'hFFFF_FFFF : k == 1 ? 32'h0 : $urandom());
            rd(OFF_HANDSHAKE);
            for (int p = 0; p < 4; p++) codec(CMD_GET_VALID, p, 0);
        end
        for (int k = 0; k < 12; k++) begin
            wr(OFF_CONTROL, 32'((k % 5) << 18));
            codec(CMD_GET_SINK_BYTE, k % 3, $urandom_range(127));
            codec(CMD_SET_PKT_INDEX, 0, $urandom_range(39));
            codec(CMD_GET_PKT_BYTE, 0, 0);
        end
        wr(OFF_HANDSHAKE, 32'h0000_0111);
        pulse(0);
        rd(OFF_HANDSHAKE);
        rd(OFF_CONTROL);
        repeat (3) rd(OFF_SINK_WINDOW);
        rd(OFF_PACKET_WINDOW);
        foreach (pkt[i, j]) load(i, j, $urandom());
        pulse(1);
        repeat (8) rd(OFF_PACKET_WINDOW);
        chk(32'(uq.size()), 32'h0000_0000);
        end_sim();
    end
endmodule // tb_top
